// ### output_compare_mode_control.v
// How it works
// - Channel 2 selector: 00 output, 01 input two, 10 input one, 11 internal trigger.
// - Internal trigger routing works only when an internal trigger source is selected.
// - Channel 2 selector is written only while channel 2 enable is zero.
// - With clear enable zero the filtered external trigger never touches the reference.
// - With clear enable at bit 7 set, a high external trigger drives reference low.
// - Mode field at 6:4 defines active-high reference; outputs follow polarity bits.
// - Mode 000 frozen: a match leaves the reference unchanged.
// - Mode 001 forces the reference high on a match.
// - Mode 010 forces the reference low on a match.
// - Mode 011 toggles the reference on every match.
// - Mode 100 holds reference low, mode 101 holds it high.
// - Mode 110: up high while counter below compare; down low while above.
// - Mode 111: up low while counter below compare; down high while above.
// - Mode bits ignore writes at lock level 3 with channel 1 as output.
// - Waveform level changes only on compare change or leaving frozen mode; here any switch into mode 110 or 111 re-evaluates it at once.
// - Preload and fast enables at bits 11, 10, 3, 2; read-write, reset zero.
// - Without preload compare writes act at once; with preload at update events.
// - Fast enable in waveform mode makes a trigger edge act as a match; here the edge sets the pre-match level instead.
//
// Added by the designer: the AHB-Lite register port and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
`include "ccmode_map.vh"

module output_compare_mode_control #(
    parameter CNT_W = 16
) (
    input  wire              clk_i,
    input  wire              resetn_i,
    input  wire              hsel_i,
    input  wire [31:0]       haddr_i,
    input  wire [1:0]        htrans_i,
    input  wire              hwrite_i,
    input  wire [2:0]        hsize_i,
    input  wire [31:0]       hwdata_i,
    input  wire              hready_i,
    output wire [31:0]       hrdata_o,
    output wire              hreadyout_o,
    output wire              hresp_o,
    input  wire [CNT_W-1:0]  counter_value_i,
    input  wire              count_down_i,
    input  wire              update_event_i,
    input  wire              trigger_edge_i,
    input  wire              ext_trigger_filtered_i,
    input  wire              internal_trigger_sel_i,
    input  wire              internal_trigger_input_i,
    input  wire              timer_input_one_i,
    input  wire              timer_input_two_i,
    input  wire              ch2_output_enable_i,
    input  wire [1:0]        lock_level_i,
    input  wire              ch1_polarity_i,
    input  wire              ch1_comp_polarity_i,
    output reg               ch1_reference_o,
    output wire              ch1_true_output_o,
    output wire              ch1_comp_output_o,
    output reg               ch2_capture_input_o,
    output wire              ch2_is_output_o,
    output wire [CNT_W-1:0]  ch1_compare_active_o
);

    // ============================================================
    // Bus slave: zero wait states, always OKAY.
    reg         wr_pend;
    reg  [11:0] wr_addr;
    reg  [31:0] rdata;
    reg  [15:0] mode_reg;
    reg  [CNT_W-1:0] cmp_shadow;
    reg  [CNT_W-1:0] cmp_active;
    wire        addr_ok = hsel_i & hready_i & htrans_i[`HTRANS_NONSEQ_BIT];
    wire        do_wr   = wr_pend;

    assign hreadyout_o = 1'b1;
    assign hresp_o     = 1'b0;
    assign hrdata_o    = rdata;

    wire [2:0] ch1_mode = mode_reg[`B_CH1_MODE_HI:`B_CH1_MODE_LO];
    wire [1:0] ch1_dir  = mode_reg[`B_CH1_DIR_HI:`B_CH1_DIR_LO];
    wire [1:0] ch2_dir  = mode_reg[`B_CH2_DIR_HI:`B_CH2_DIR_LO];

    function is_pwm;
        input [2:0] m;
        begin
            is_pwm = (m == `MODE_PWM1) || (m == `MODE_PWM2);
        end
    endfunction

    // Lock and direction guards shared by the write path.
    wire mode_locked = (lock_level_i == `LOCK_LEVEL_3) && (ch1_dir == `DIR_OUTPUT);

    always @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            wr_pend <= 1'b0;
            wr_addr <= 12'h000;
            rdata   <= `ZERO32;
        end else begin
            wr_pend <= addr_ok & hwrite_i;
            if (addr_ok) begin
                wr_addr <= haddr_i[11:0];
            end
            if (addr_ok & ~hwrite_i) begin
                case (haddr_i[11:0])
                    `OFF_MODE_CTRL:   rdata <= {16'h0000, mode_reg};
                    `OFF_CH1_COMPARE: rdata <= {{(32-CNT_W){1'b0}}, cmp_shadow};
                    `OFF_CH1_ACTIVE:  rdata <= {{(32-CNT_W){1'b0}}, cmp_active};
                    `OFF_STATUS:      rdata <= {30'h0000_0000, ch2_capture_input_o,
                                                ch1_reference_o};
                    default:          rdata <= `ZERO32;
                endcase
            end
        end
    end

    // ============================================================
    // Mode register and compare value.
    wire mode_wr = do_wr && (wr_addr == `OFF_MODE_CTRL);
    wire cmp_wr  = do_wr && (wr_addr == `OFF_CH1_COMPARE);

    always @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            mode_reg   <= 16'h0000;
            cmp_shadow <= {CNT_W{1'b0}};
            cmp_active <= {CNT_W{1'b0}};
        end else begin
            if (mode_wr) begin
                mode_reg[`B_CH2_PRELOAD] <= hwdata_i[`B_CH2_PRELOAD];
                mode_reg[`B_CH2_FAST]    <= hwdata_i[`B_CH2_FAST];
                mode_reg[`B_CH1_PRELOAD] <= hwdata_i[`B_CH1_PRELOAD];
                mode_reg[`B_CH1_FAST]    <= hwdata_i[`B_CH1_FAST];
                mode_reg[`B_CH1_CLEAR]   <= hwdata_i[`B_CH1_CLEAR];
                mode_reg[`B_CH1_DIR_HI:`B_CH1_DIR_LO] <= hwdata_i[`B_CH1_DIR_HI:`B_CH1_DIR_LO];
                mode_reg[`B_CH2_UPPER_HI:`B_CH2_UPPER_LO] <=
                    hwdata_i[`B_CH2_UPPER_HI:`B_CH2_UPPER_LO];
                if (!ch2_output_enable_i) begin
                    mode_reg[`B_CH2_DIR_HI:`B_CH2_DIR_LO] <=
                        hwdata_i[`B_CH2_DIR_HI:`B_CH2_DIR_LO];
                end
                if (!mode_locked) begin
                    mode_reg[`B_CH1_MODE_HI:`B_CH1_MODE_LO] <=
                        hwdata_i[`B_CH1_MODE_HI:`B_CH1_MODE_LO];
                end
            end
            if (cmp_wr) begin
                cmp_shadow <= hwdata_i[CNT_W-1:0];
            end
            // Write-through when preload is off; the shadow moves on update otherwise.
            if (!mode_reg[`B_CH1_PRELOAD] && cmp_wr) begin
                cmp_active <= hwdata_i[CNT_W-1:0];
            end else if (mode_reg[`B_CH1_PRELOAD] && update_event_i) begin
                cmp_active <= cmp_shadow;
            end
        end
    end

    assign ch1_compare_active_o = cmp_active;

    // ============================================================
    // Channel 2 direction and capture routing.
    assign ch2_is_output_o = (ch2_dir == `DIR_OUTPUT);

    always @* begin
        case (ch2_dir)
            `DIR_IN_TWO:  ch2_capture_input_o = timer_input_two_i;
            `DIR_IN_ONE:  ch2_capture_input_o = timer_input_one_i;
            `DIR_IN_TRIG: ch2_capture_input_o = internal_trigger_sel_i &
                                                internal_trigger_input_i;
            default:      ch2_capture_input_o = 1'b0;
        endcase
    end

    // ============================================================
    // Channel 1 reference generation.
    // Counter and direction are sampled straight from the core each cycle, compare from cmp_active.
    wire match   = (counter_value_i == cmp_active);
    wire below   = (counter_value_i < cmp_active);
    wire above   = (counter_value_i > cmp_active);
    wire pwm_hit = mode_reg[`B_CH1_FAST] & trigger_edge_i;
    reg  next_ref;

    always @* begin
        next_ref = ch1_reference_o;
        case (ch1_mode)
            `MODE_FROZEN:     next_ref = ch1_reference_o;
            `MODE_SET:        if (match) next_ref = 1'b1;
            `MODE_CLEAR:      if (match) next_ref = 1'b0;
            `MODE_TOGGLE:     if (match) next_ref = ~ch1_reference_o;
            `MODE_FORCE_LOW:  next_ref = 1'b0;
            `MODE_FORCE_HIGH: next_ref = 1'b1;
            // The level is a pure function of the comparison, so it moves when the comparison
            // result changes or the mode switches into 110 or 111 from any other mode.
            `MODE_PWM1:       next_ref = count_down_i ? ~above : below;
            `MODE_PWM2:       next_ref = count_down_i ? above : ~below;
            default:          next_ref = ch1_reference_o;
        endcase
        // A fast trigger edge jumps straight to the pre-match level: high for 110 up or 111 down, low otherwise.
        if (pwm_hit && is_pwm(ch1_mode)) begin
            next_ref = (ch1_mode == `MODE_PWM1) ? ~count_down_i : count_down_i;
        end
        if (mode_reg[`B_CH1_CLEAR] && ext_trigger_filtered_i) begin
            next_ref = 1'b0;
        end
    end

    always @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            ch1_reference_o <= 1'b0;
        end else begin
            ch1_reference_o <= next_ref;
        end
    end

    // Polarity applies only in the output stage; the reference stays active high.
    assign ch1_true_output_o = ch1_reference_o ^ ch1_polarity_i;
    assign ch1_comp_output_o = ~ch1_reference_o ^ ch1_comp_polarity_i;

endmodule // output_compare_mode_control
`default_nettype wire

// ### ccmode_map.vh
`ifndef CCMODE_MAP_VH
`define CCMODE_MAP_VH

// ============================================================
// Register offsets (byte addresses).
`define OFF_MODE_CTRL     12'h000
`define OFF_CH1_COMPARE   12'h004
`define OFF_CH1_ACTIVE    12'h008
`define OFF_STATUS        12'h00C

// ============================================================
// Field positions of channel_mode_control_1.
`define B_CH1_DIR_LO      0
`define B_CH1_DIR_HI      1
`define B_CH1_FAST        2
`define B_CH1_PRELOAD     3
`define B_CH1_MODE_LO     4
`define B_CH1_MODE_HI     6
`define B_CH1_CLEAR       7
`define B_CH2_DIR_LO      8
`define B_CH2_DIR_HI      9
`define B_CH2_FAST        10
`define B_CH2_PRELOAD     11
`define B_CH2_UPPER_LO    12
`define B_CH2_UPPER_HI    15

// ============================================================
// Encodings.
`define DIR_OUTPUT        2'b00
`define DIR_IN_TWO        2'b01
`define DIR_IN_ONE        2'b10
`define DIR_IN_TRIG       2'b11
`define MODE_FROZEN       3'b000
`define MODE_SET          3'b001
`define MODE_CLEAR        3'b010
`define MODE_TOGGLE       3'b011
`define MODE_FORCE_LOW    3'b100
`define MODE_FORCE_HIGH   3'b101
`define MODE_PWM1         3'b110
`define MODE_PWM2         3'b111
`define LOCK_LEVEL_3      2'b11
`define ZERO32            32'h0000_0000
`define HTRANS_NONSEQ_BIT 1

`endif

// ### ocmc_props.sv
`timescale 1ns/10ps
`default_nettype none
// ============================================================
// Port checker. A shadow of the mode bits is rebuilt from bus writes.
module ocmc_props #(parameter CNT_W = 16) (
    input wire logic             clk_i,
    input wire logic             resetn_i,
    input wire logic             hsel_i,
    input wire logic [31:0]      haddr_i,
    input wire logic [1:0]       htrans_i,
    input wire logic             hwrite_i,
    input wire logic [31:0]      hwdata_i,
    input wire logic             hready_i,
    input wire logic [CNT_W-1:0] counter_value_i,
    input wire logic             update_event_i,
    input wire logic             ext_trigger_filtered_i,
    input wire logic             internal_trigger_sel_i,
    input wire logic             internal_trigger_input_i,
    input wire logic             timer_input_one_i,
    input wire logic             timer_input_two_i,
    input wire logic             ch2_output_enable_i,
    input wire logic [1:0]       lock_level_i,
    input wire logic             ch1_polarity_i,
    input wire logic             ch1_comp_polarity_i,
    input wire logic             ch1_reference_o,
    input wire logic             ch1_true_output_o,
    input wire logic             ch1_comp_output_o,
    input wire logic             ch2_capture_input_o,
    input wire logic             ch2_is_output_o,
    input wire logic [CNT_W-1:0] ch1_compare_active_o
);
    logic [15:0] sh;
    logic [15:0] next_sh;
    logic        wp;
    logic        wc;
    wire         clr = sh[7] & ext_trigger_filtered_i;
    wire         req = hsel_i & hready_i & htrans_i[1] & hwrite_i;
    always_comb begin
        next_sh = hwdata_i[15:0];
        if (ch2_output_enable_i) next_sh[9:8] = sh[9:8];
        if (lock_level_i == 2'b11 && sh[1:0] == 2'b00) next_sh[6:4] = sh[6:4];
    end
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            sh <= 16'h0000;
            wp <= 1'b0;
            wc <= 1'b0;
        end else begin
            wp <= req && haddr_i[11:0] == 12'h000;
            wc <= req && haddr_i[11:0] == 12'h004;
            if (wp) sh <= next_sh;
        end
    end
    default clocking @(posedge clk_i); endclocking
    default disable iff (!resetn_i);
    sequence s_hit;
        counter_value_i == ch1_compare_active_o && !clr;
    endsequence
    a_true_polarity: assert property (ch1_true_output_o == (ch1_reference_o ^ ch1_polarity_i))
        else $error("true output polarity wrong");
    a_comp_polarity: assert property (ch1_comp_output_o == (!ch1_reference_o ^ ch1_comp_polarity_i))
        else $error("complementary output polarity wrong");
    a_is_output: assert property (ch2_is_output_o == (sh[9:8] == 2'b00))
        else $error("channel two direction flag wrong");
    a_dir_route: assert property (sh[9:8] != 2'b00 |-> ch2_capture_input_o == (sh[9:8] == 2'b01 ?
        timer_input_two_i : sh[9:8] == 2'b10 ? timer_input_one_i :
        internal_trigger_sel_i & internal_trigger_input_i)) else $error("capture input routing wrong");
    a_clear_wins: assert property (clr |=> !ch1_reference_o)
        else $error("reference not cleared");
    a_force_level: assert property (sh[6:5] == 2'b10 && !clr |=> ch1_reference_o == $past(sh[4]))
        else $error("forced level wrong");
    a_match_level: assert property ((sh[6:4] == 3'b001 || sh[6:4] == 3'b010) ##0 s_hit
        |=> ch1_reference_o == $past(sh[4])) else $error("match level wrong");
    a_toggle_match: assert property (sh[6:4] == 3'b011 ##0 s_hit |=> $changed(ch1_reference_o))
        else $error("toggle missing");
    a_frozen_hold: assert property (sh[6:4] == 3'b000 && !clr |=> $stable(ch1_reference_o))
        else $error("frozen reference moved");
    a_compare_src: assert property ($changed(ch1_compare_active_o) |-> $past(wc) || $past(update_event_i))
        else $error("active compare changed without cause");
endmodule // ocmc_props
bind output_compare_mode_control ocmc_props #(.CNT_W(CNT_W)) u_props (.*);
`default_nettype wire

// ### cnt_core_model.sv
`timescale 1ns/10ps
`default_nettype none
// ============================================================
// Counter core stand-in. The update event marks the wrap so preloads land between periods.
module cnt_core_model #(parameter CNT_W = 16, parameter TOP = 63) (
    input  wire logic             clk_i,
    input  wire logic             resetn_i,
    input  wire logic             down_i,
    output var  logic [CNT_W-1:0] counter_value_o,
    output var  logic             update_event_o
);
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) counter_value_o <= '0;
        else if (down_i) counter_value_o <= (counter_value_o == 0) ? TOP : counter_value_o - 1'b1;
        else counter_value_o <= (counter_value_o == TOP) ? '0 : counter_value_o + 1'b1;
    end
    assign update_event_o = counter_value_o == (down_i ? 0 : TOP);
endmodule // cnt_core_model
`default_nettype wire

// ### tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    logic        clk_i, resetn_i, hsel, hwrite, ext, isel, itrig, ti1, ti2, c2en, pol, cpol, down;
    logic        rf, t_o, c_o, cap, iso, upd, rdy, resp, trig;
    logic [1:0]  htrans, lock;
    logic [31:0] haddr, hwdata, hrdata, v;
    logic [15:0] cnt, act;
    int          error_cnt = 0, checked = 0;
    cnt_core_model u_cnt (.clk_i(clk_i), .resetn_i(resetn_i), .down_i(down),
        .counter_value_o(cnt), .update_event_o(upd));
    output_compare_mode_control uut (.clk_i(clk_i), .resetn_i(resetn_i), .hsel_i(hsel),
        .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'b010),
        .hwdata_i(hwdata), .hready_i(rdy), .hrdata_o(hrdata), .hreadyout_o(rdy), .hresp_o(resp),
        .counter_value_i(cnt), .count_down_i(down), .update_event_i(upd), .trigger_edge_i(trig),
        .ext_trigger_filtered_i(ext), .internal_trigger_sel_i(isel),
        .internal_trigger_input_i(itrig), .timer_input_one_i(ti1), .timer_input_two_i(ti2),
        .ch2_output_enable_i(c2en), .lock_level_i(lock), .ch1_polarity_i(pol),
        .ch1_comp_polarity_i(cpol), .ch1_reference_o(rf), .ch1_true_output_o(t_o),
        .ch1_comp_output_o(c_o), .ch2_capture_input_o(cap), .ch2_is_output_o(iso),
        .ch1_compare_active_o(act));
    task chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Each task starts just after an edge and holds every phase until hready is seen high.
    task xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
        hsel <= 1'b1; haddr <= a; htrans <= 2'b10; hwrite <= w;
        do @(posedge clk_i); while (!rdy);
        hsel <= 1'b0; htrans <= 2'b00; hwdata <= d;
        do @(posedge clk_i); while (!rdy);
        v = hrdata;
    endtask
    task ref_after(input logic [31:0] mode, input logic e);
        xfer(1'b1, 32'h0000_0000, mode);
        repeat (2) @(posedge clk_i);
        #1 chk(rf, e);
    endtask
    task hit(input logic e);
        @(posedge clk_i iff cnt == 16'h0009);
        #1 chk(rf, e);
    endtask
    task t_regs;
        xfer(1'b0, 32'h0000_0000, 32'h0000_0000); chk(v, 32'h0000_0000);
        xfer(1'b1, 32'h0000_0000, 32'h0000_0C08);
        xfer(1'b0, 32'h0000_0000, 32'h0000_0000); chk(v, 32'h0000_0C08);
        xfer(1'b0, 32'h0000_0010, 32'h0000_0000); chk(v, 32'h0000_0000);
    endtask
    task t_preload;
        @(posedge clk_i iff upd);
        xfer(1'b1, 32'h0000_0004, 32'h0000_0009);
        #1 chk(act, 16'h0000);
        @(posedge clk_i iff upd);
        #1 chk(act, 16'h0009);
        xfer(1'b1, 32'h0000_0000, 32'h0000_0000);
        xfer(1'b1, 32'h0000_0004, 32'h0000_0005);
        #1 chk(act, 16'h0005);
        xfer(1'b1, 32'h0000_0004, 32'h0000_0009);
    endtask
    task t_dir;
        itrig <= 1'b1;
        xfer(1'b1, 32'h0000_0000, 32'h0000_0100); #1 chk(cap, 1'b1);
        xfer(1'b1, 32'h0000_0000, 32'h0000_0200); #1 chk(cap, 1'b0);
        xfer(1'b1, 32'h0000_0000, 32'h0000_0300); #1 chk(cap, 1'b1);
        isel <= 1'b0;
        @(posedge clk_i); #1 chk(cap, 1'b0);
        c2en <= 1'b1;
        xfer(1'b1, 32'h0000_0000, 32'h0000_0000);
        xfer(1'b0, 32'h0000_0000, 32'h0000_0000); chk(v, 32'h0000_0300);
        c2en <= 1'b0;
        xfer(1'b1, 32'h0000_0000, 32'h0000_0000); #1 chk(iso, 1'b1);
    endtask
    task t_ref;
        ext <= 1'b1;
        ref_after(32'h0000_0050, 1'b1);
        chk({t_o, c_o}, 2'b00);
        ref_after(32'h0000_00D0, 1'b0);
        ext <= 1'b0;
        ref_after(32'h0000_0040, 1'b0);
        // Keep the mode writes clear of a match so the settle checks are stable.
        @(posedge clk_i iff cnt == 16'h0020);
        ref_after(32'h0000_0010, 1'b0); hit(1'b1);
        ref_after(32'h0000_0020, 1'b1); hit(1'b0);
        ref_after(32'h0000_0030, 1'b0); hit(1'b1); hit(1'b0);
        ref_after(32'h0000_0050, 1'b1);
        ref_after(32'h0000_0000, 1'b1); hit(1'b1);
        xfer(1'b1, 32'h0000_0000, 32'h0000_0064);
        @(posedge clk_i iff cnt == 16'h0003);
        #1 chk(rf, 1'b1);
        @(posedge clk_i iff cnt == 16'h0014);
        trig <= 1'b1;
        @(posedge clk_i);
        trig <= 1'b0;
        #1 chk(rf, 1'b1);
        @(posedge clk_i);
        #1 chk(rf, 1'b0);
        xfer(1'b1, 32'h0000_0000, 32'h0000_0070);
        @(posedge clk_i iff cnt == 16'h0003);
        #1 chk(rf, 1'b0);
        @(posedge clk_i iff cnt == 16'h0014);
        #1 chk(rf, 1'b1);
        xfer(1'b1, 32'h0000_0000, 32'h0000_0020);
        lock <= 2'b11;
        xfer(1'b1, 32'h0000_0000, 32'h0000_0040);
        xfer(1'b0, 32'h0000_0000, 32'h0000_0000); chk(v, 32'h0000_0020);
    endtask
    task conclude;
        $display("comparisons %0d mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end
    initial begin
        repeat (20000) @(posedge clk_i);
        error_cnt++;
        conclude();
    end
    initial begin
        {resetn_i, hsel, hwrite, ext, itrig, ti1, c2en, cpol, down, htrans, lock, trig} = '0;
        {isel, ti2, pol} = 3'b111;
        haddr = 32'h0000_0000;
        hwdata = 32'h0000_0000;
        repeat (10) @(posedge clk_i);
        resetn_i <= 1'b1;
        @(posedge clk_i);
        t_regs();
        t_preload();
        t_dir();
        t_ref();
        conclude();
    end
endmodule // tb_top
`default_nettype wire
